// ===== pkg/pwm_timer_pkg.sv
// ****************************************************************
// Shared constants for the match based pwm timer
// ****************************************************************
package pwm_timer_pkg;
    // Counter and prescaler width
    localparam int CNT_W = 32;
    // Number of match registers, index 0 is the period match
    localparam int NUM_MATCH = 7;
    // Number of pwm outputs (channels 1..6)
    localparam int NUM_PWM = 6;
    // Number of capture inputs
    localparam int NUM_CAP = 2;
    // Reset value of counts and match values
    localparam logic [31:0] ZERO_32 = 32'h0000_0000;
    // Match action field positions, three bits per match
    localparam int ACT_INT = 0;
    localparam int ACT_RST = 1;
    localparam int ACT_STOP = 2;
    // Capture control field positions, three bits per input
    localparam int CAP_RISE = 0;
    localparam int CAP_FALL = 1;
    localparam int CAP_INT = 2;
    // External match output actions
    localparam logic [1:0] EXT_NONE = 2'h0;
    localparam logic [1:0] EXT_LOW = 2'h1;
    localparam logic [1:0] EXT_HIGH = 2'h2;
    localparam logic [1:0] EXT_TOGGLE = 2'h3;
    // Count mode select values
    localparam logic [1:0] MODE_TIMER = 2'h0;
    localparam logic [1:0] MODE_RISE = 2'h1;
    localparam logic [1:0] MODE_FALL = 2'h2;
    localparam logic [1:0] MODE_BOTH = 2'h3;
endpackage : pwm_timer_pkg

// ===== rtl/pwm_sync_edge.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Two flop synchroniser with edge detection on the second stage
// ****************************************************************
module pwm_sync_edge
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    // First stage is read only by the second stage
    logic meta_q;
    logic sync_q;
    logic last_q;

    // Synchroniser chain plus one history stage
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end
        else
        begin
            meta_q <= pin;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // Edges derived from settled stages only
    assign level = sync_q;
    assign rise = sync_q & ~last_q;
    assign fall = ~sync_q & last_q;
endmodule : pwm_sync_edge
`default_nettype wire

// ===== rtl/match_based_pwm_timer.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - 32-bit counter stepped by 32-bit prescaler
// - Timer or capture-clocked counter mode
// - Seven match registers drive pwm outputs
// - Match may continue, stop or reset
// - Period match resets count, new cycle
// - Single-edge outputs rise at period match
// - Constant-low outputs never rise
// - Double-edge uses two matches, either order
// - Common period, any count widths
// - Released match values apply at cycle start
// - Without pwm mode, plain timer behaviour
// - Start output high while enabled but not running
// - Capture count on input edge
// - External match low, high, toggle, none
module match_based_pwm_timer
    import pwm_timer_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    // Software enables and controls
    input wire logic count_enable,
    input wire logic count_reset,
    input wire logic pwm_enable,
    input wire logic sync_start,
    input wire logic [1:0] count_mode,
    input wire logic count_cap_sel,
    input wire logic [31:0] prescale_max,
    // Match register write port
    input wire logic match_wr,
    input wire logic [2:0] match_wr_idx,
    input wire logic [31:0] match_wr_data,
    input wire logic [NUM_MATCH-1:0] match_release,
    input wire logic [3*NUM_MATCH-1:0] match_action,
    input wire logic [2*NUM_MATCH-1:0] ext_action,
    // Per channel: 1 selects double edge (channels 2..6)
    input wire logic [NUM_PWM-1:0] double_edge_sel,
    input wire logic [NUM_PWM-1:0] pwm_out_enable,
    // Capture configuration and pins
    input wire logic [3*NUM_CAP-1:0] cap_ctrl,
    input wire logic [NUM_CAP-1:0] cap_pin,
    // Flag clear, write one to clear
    input wire logic [NUM_MATCH+NUM_CAP-1:0] flag_clear,
    // Status
    output logic [31:0] count_value,
    output logic [31:0] prescale_value,
    output logic [32*NUM_CAP-1:0] cap_value,
    output logic [NUM_MATCH+NUM_CAP-1:0] flag_pending,
    output logic [NUM_MATCH-1:0] ext_match,
    output logic [NUM_PWM-1:0] pwm_out,
    output logic sync_start_out
);
    // ************************************************************
    // Storage
    // ************************************************************
    // Active and shadow match values
    logic [31:0] match_q [NUM_MATCH];
    logic [31:0] shadow_q [NUM_MATCH];
    // Release latches waiting for period boundary
    logic [NUM_MATCH-1:0] pend_q;
    // Counter and prescaler
    logic [31:0] tc_q;
    logic [31:0] pc_q;
    logic running_q;
    logic halted_q;
    // Synchronised capture pin edges
    logic [NUM_CAP-1:0] cap_rise;
    logic [NUM_CAP-1:0] cap_fall;
    // Count step and match hits
    logic step;
    logic [NUM_MATCH-1:0] hit;
    logic cyc_reset;
    logic stop_hit;
    logic [NUM_CAP-1:0] cap_ev;

    // ************************************************************
    // Capture input synchronisers
    // ************************************************************
    generate
        for (genvar gi = 0; gi < NUM_CAP; gi++)
        begin : g_cap
            pwm_sync_edge u_sync
            (
                .clock(clock),
                .rst_b(rst_b),
                .pin(cap_pin[gi]),
                .level(),
                .rise(cap_rise[gi]),
                .fall(cap_fall[gi])
            );
            assign cap_ev[gi] =
                (cap_rise[gi] & cap_ctrl[3*gi+CAP_RISE]) |
                (cap_fall[gi] & cap_ctrl[3*gi+CAP_FALL]);
        end
    endgenerate

    // ************************************************************
    // Count source and prescaler
    // ************************************************************
    logic src_tick, src_rise, src_fall;
    // Edges of the selected capture pin
    assign src_rise = count_cap_sel ? cap_rise[1] : cap_rise[0];
    assign src_fall = count_cap_sel ? cap_fall[1] : cap_fall[0];

    always_comb
    begin
        case (count_mode)
            MODE_TIMER: src_tick = 1'b1;
            MODE_RISE: src_tick = src_rise;
            MODE_FALL: src_tick = src_fall;
            MODE_BOTH: src_tick = src_rise | src_fall;
            default: src_tick = 1'b0;
        endcase
    end

    // Count advances when prescaler wraps
    assign step = running_q && src_tick && (pc_q == prescale_max);

    always_ff @(posedge clock)
    begin
        if (!rst_b || count_reset)
            pc_q <= ZERO_32;
        else if (running_q && src_tick)
            pc_q <= (pc_q == prescale_max) ? ZERO_32 : pc_q + 32'h0000_0001;
    end

    // ************************************************************
    // Match compare
    // ************************************************************
    // Compare on the counted value so a hit lasts one step
    always_comb
    begin
        for (int i = 0; i < NUM_MATCH; i++)
            hit[i] = step && (tc_q == match_q[i]);
    end

    always_comb
    begin
        cyc_reset = 1'b0;
        stop_hit = 1'b0;
        for (int i = 0; i < NUM_MATCH; i++)
        begin
            cyc_reset = cyc_reset | (hit[i] & match_action[3*i+ACT_RST]);
            stop_hit = stop_hit | (hit[i] & match_action[3*i+ACT_STOP]);
        end
        // period match restarts cycle in pwm mode
        if (pwm_enable && hit[0])
            cyc_reset = 1'b1;
    end

    // ************************************************************
    // Timer counter and run control
    // ************************************************************
    // counter steps once per prescale period
    always_ff @(posedge clock)
    begin
        if (!rst_b || count_reset)
            tc_q <= ZERO_32;
        else if (cyc_reset)
            tc_q <= ZERO_32;
        else if (step && !stop_hit)
            tc_q <= tc_q + 32'h0000_0001;
    end

    // run starts when enable and primary start are both high
    always_ff @(posedge clock)
    begin
        if (!rst_b || !count_enable)
        begin
            running_q <= 1'b0;
            halted_q <= 1'b0;
        end
        // stop on match holds until enable drops
        else if (stop_hit)
        begin
            running_q <= 1'b0;
            halted_q <= 1'b1;
        end
        else if (sync_start && !halted_q)
            running_q <= 1'b1;
    end

    // Start pulse handed to a secondary unit, registered
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            sync_start_out <= 1'b0;
        else
            sync_start_out <= count_enable && !running_q;
    end

    // ************************************************************
    // Match registers with release
    // ************************************************************
    // shadow written, applied at period boundary in pwm mode, at once otherwise
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            pend_q <= '0;
            for (int i = 0; i < NUM_MATCH; i++)
            begin
                match_q[i] <= ZERO_32;
                shadow_q[i] <= ZERO_32;
            end
        end
        else
            for (int i = 0; i < NUM_MATCH; i++)
            begin
                if (match_wr && match_wr_idx == 3'(i))
                    shadow_q[i] <= match_wr_data;
                if (!pwm_enable)
                    match_q[i] <= (match_wr && match_wr_idx == 3'(i)) ?
                                  match_wr_data : shadow_q[i];
                else if (pend_q[i] && (cyc_reset || !running_q))
                    match_q[i] <= shadow_q[i];
                // Release stays pending until applied
                if (!pwm_enable || (pend_q[i] && (cyc_reset || !running_q)))
                    pend_q[i] <= 1'b0;
                if (pwm_enable && match_release[i])
                    pend_q[i] <= 1'b1;
            end
    end

    // ************************************************************
    // PWM outputs
    // ************************************************************
    // channel n uses match n, double edge uses n-1 too
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            pwm_out <= '0;
        else
            for (int n = 1; n <= NUM_PWM; n++)
            begin
                if (!pwm_enable || !pwm_out_enable[n-1])
                    pwm_out[n-1] <= 1'b0;
                else if (double_edge_sel[n-1] && n > 1)
                begin
                    // rise on match n-1, fall on match n
                    if (hit[n])
                        pwm_out[n-1] <= 1'b0;
                    else if (hit[n-1])
                        pwm_out[n-1] <= 1'b1;
                end
                else
                begin
                    // fall wins, so constant low stays low
                    if (hit[n])
                        pwm_out[n-1] <= 1'b0;
                    // all channels share match 0 period
                    else if (hit[0])
                        pwm_out[n-1] <= 1'b1;
                end
            end
    end

    // ************************************************************
    // External match outputs
    // ************************************************************
    // per match low, high, toggle or nothing
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            ext_match <= '0;
        else
            for (int i = 0; i < NUM_MATCH; i++)
            begin
                if (hit[i])
                begin
                    case (ext_action[2*i +: 2])
                        EXT_LOW: ext_match[i] <= 1'b0;
                        EXT_HIGH: ext_match[i] <= 1'b1;
                        EXT_TOGGLE: ext_match[i] <= ~ext_match[i];
                        default: ext_match[i] <= ext_match[i];
                    endcase
                end
            end
    end

    // ************************************************************
    // Capture registers and flags
    // ************************************************************
    // snapshot count on selected edge
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            cap_value <= '0;
        else
            for (int c = 0; c < NUM_CAP; c++)
                if (cap_ev[c])
                    cap_value[32*c +: 32] <= tc_q;
    end

    // sticky flags, a new event beats the clear
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            flag_pending <= '0;
        else
        begin
            for (int i = 0; i < NUM_MATCH; i++)
                flag_pending[i] <= (hit[i] & match_action[3*i+ACT_INT]) |
                                   (flag_pending[i] & ~flag_clear[i]);
            for (int c = 0; c < NUM_CAP; c++)
                flag_pending[NUM_MATCH+c] <=
                    (cap_ev[c] & cap_ctrl[3*c+CAP_INT]) |
                    (flag_pending[NUM_MATCH+c] & ~flag_clear[NUM_MATCH+c]);
        end
    end

    // Registered status copies
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            count_value <= ZERO_32;
            prescale_value <= ZERO_32;
        end
        else
        begin
            count_value <= tc_q;
            prescale_value <= pc_q;
        end
    end
endmodule : match_based_pwm_timer
`default_nettype wire

// ===== testbench/pwm_timer_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Port level checks for the match based pwm timer
// ****************************************************************
module pwm_timer_monitor
    import pwm_timer_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic count_enable,
    input wire logic count_reset,
    input wire logic pwm_enable,
    input wire logic sync_start,
    input wire logic [1:0] count_mode,
    input wire logic [31:0] prescale_max,
    input wire logic [3*NUM_MATCH-1:0] match_action,
    input wire logic [3*NUM_CAP-1:0] cap_ctrl,
    input wire logic [NUM_CAP-1:0] cap_pin,
    input wire logic [NUM_MATCH+NUM_CAP-1:0] flag_clear,
    input wire logic [31:0] count_value,
    input wire logic [31:0] prescale_value,
    input wire logic [32*NUM_CAP-1:0] cap_value,
    input wire logic [NUM_MATCH+NUM_CAP-1:0] flag_pending,
    input wire logic [NUM_PWM-1:0] pwm_out
);
    // One clock domain, every check muted while reset is low
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    chk_reset_clear: assert property ($rose(rst_b) |->
        count_value == ZERO_32 && pwm_out == 6'h00 && flag_pending == 9'h000)
        else $error("outputs not zero after reset");
    chk_count_step: assert property (count_value != $past(count_value) |->
        count_value == ZERO_32 || count_value == $past(count_value) + 32'h1)
        else $error("count jumped");
    chk_hold_zero: assert property (count_reset ##1 count_reset |=>
        count_value == ZERO_32)
        else $error("count not held at zero");
    chk_stop_hold: assert property ((!count_enable && !count_reset) [*4] |->
        count_value == $past(count_value))
        else $error("count moved while disabled");
    // Plain timer with no match actions must step every clock
    chk_timer_steps: assert property ((count_enable && sync_start &&
        !count_reset && !pwm_enable && count_mode == MODE_TIMER &&
        prescale_max == ZERO_32 && match_action == 21'h000000) [*4] |=>
        count_value != $past(count_value))
        else $error("timer did not step");
    chk_prescale_bound: assert property ($stable(prescale_max) [*3] |->
        prescale_value <= prescale_max)
        else $error("prescaler beyond its limit");
    chk_cap_quiet: assert property ($stable(cap_pin[0]) [*6] |->
        $stable(cap_value[31:0]))
        else $error("capture without pin edge");
    chk_cap_noflag: assert property (!cap_ctrl[CAP_INT] [*6] |->
        !$rose(flag_pending[NUM_MATCH]))
        else $error("capture flag while masked");
    chk_flag_sticky: assert property ((($past(flag_pending) &
        ~flag_pending) & ~$past(flag_clear)) == 9'h000)
        else $error("flag dropped without clear");
endmodule : pwm_timer_monitor
bind match_based_pwm_timer pwm_timer_monitor pwm_timer_monitor_inst (.clock,
    .rst_b, .count_enable, .count_reset, .pwm_enable, .sync_start,
    .count_mode, .prescale_max, .match_action, .cap_ctrl, .cap_pin,
    .flag_clear, .count_value, .prescale_value, .cap_value, .flag_pending,
    .pwm_out);
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import pwm_timer_pkg::*;
;
    // ****************************************************************
    // Stimulus, observed ports and tallies
    // ****************************************************************
    logic clock, rst_b, count_enable, count_reset, pwm_enable, sync_start;
    logic count_cap_sel, match_wr, sync_start_out;
    logic [1:0] count_mode;
    logic [2:0] match_wr_idx;
    logic [31:0] prescale_max, match_wr_data, count_value, prescale_value;
    logic [NUM_MATCH-1:0] match_release, ext_match;
    logic [3*NUM_MATCH-1:0] match_action;
    logic [2*NUM_MATCH-1:0] ext_action;
    logic [NUM_PWM-1:0] double_edge_sel, pwm_out_enable, pwm_out;
    logic [3*NUM_CAP-1:0] cap_ctrl;
    logic [NUM_CAP-1:0] cap_pin;
    logic [NUM_MATCH+NUM_CAP-1:0] flag_clear, flag_pending;
    logic [32*NUM_CAP-1:0] cap_value;
    logic [31:0] cmax;
    int num_errors, cmp_count, hc [NUM_PWM];
    match_based_pwm_timer match_based_pwm_timer_inst (.clock, .rst_b,
        .count_enable, .count_reset, .pwm_enable, .sync_start, .count_mode,
        .count_cap_sel, .prescale_max, .match_wr, .match_wr_idx,
        .match_wr_data, .match_release, .match_action, .ext_action,
        .double_edge_sel, .pwm_out_enable, .cap_ctrl, .cap_pin, .flag_clear,
        .count_value, .prescale_value, .cap_value, .flag_pending,
        .ext_match, .pwm_out, .sync_start_out);
    // 125 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick
    task automatic check(input logic ok, input string what);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            num_errors++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : check
    // Prescale limit only drops here, so it never lands below a live count
    task automatic do_reset;
        rst_b <= 1'b0;
        {count_enable, pwm_enable, count_mode} <= 4'h0;
        {prescale_max, match_action} <= 53'h0;
        {double_edge_sel, pwm_out_enable, cap_ctrl, cap_pin} <= 20'h0;
        tick(2);
        rst_b <= 1'b1;
        tick(1);
    endtask : do_reset
    task automatic set_match(input int i, input logic [31:0] v, input logic r);
        match_wr <= 1'b1;
        match_wr_idx <= 3'(i);
        match_wr_data <= v;
        tick(1);
        match_wr <= 1'b0;
        match_release <= {6'h00, r} << i;
        tick(1);
        match_release <= 7'h00;
    endtask : set_match
    // Count advance over n cycles, sampled away from the edge
    task automatic delta(input int n, output logic [31:0] d);
        logic [31:0] c0;
        @(negedge clock);
        c0 = count_value;
        tick(n);
        @(negedge clock);
        d = count_value - c0;
        @(posedge clock);
    endtask : delta
    // High cycles per output and largest count seen over n cycles
    task automatic measure(input int n);
        hc = '{default: 0};
        cmax = ZERO_32;
        repeat (n)
        begin
            @(negedge clock);
            foreach (hc[k]) hc[k] += int'(pwm_out[k]);
            if (count_value > cmax)
                cmax = count_value;
        end
        @(posedge clock);
    endtask : measure
    task automatic t_timer;
        logic [31:0] d;
        do_reset;
        count_enable <= 1'b1;
        tick(5);
        delta(30, d);
        check(d === 32'h1E, "timer count");
        count_reset <= 1'b1;
        prescale_max <= 32'h2;
        tick(2);
        count_reset <= 1'b0;
        tick(4);
        delta(30, d);
        check(d === 32'h0A, "prescaled count");
        count_enable <= 1'b0;
        tick(3);
        delta(10, d);
        check(d === ZERO_32, "held count");
        // Secondary style start: counting waits for the start qualifier
        sync_start <= 1'b0;
        count_enable <= 1'b1;
        tick(3);
        delta(30, d);
        check(d === ZERO_32 && sync_start_out === 1'b1, "wait start");
        sync_start <= 1'b1;
        tick(3);
        delta(30, d);
        check(d === 32'h0A && sync_start_out === 1'b0, "joint start");
    endtask : t_timer
    // Period, single edge, constant low, both double edge polarities
    task automatic t_pwm;
        logic [31:0] mv [NUM_MATCH] = '{32'h9, 32'h4, 32'h9, 32'h2, 32'h6,
            32'h7, 32'h3};
        do_reset;
        pwm_enable <= 1'b1;
        match_action <= 21'h000003;
        double_edge_sel <= 6'h28;
        pwm_out_enable <= 6'h2B;
        foreach (mv[i]) set_match(i, mv[i], 1'b1);
        count_enable <= 1'b1;
        tick(25);
        measure(20);
        check(cmax === 32'h9, "period");
        check(hc[0] == 10 && hc[3] == 8, "positive pulses");
        check(hc[5] == 12, "negative pulse");
        check(hc[1] == 0 && pwm_out[1] === 1'b0, "constant low");
        check(flag_pending[0] === 1'b1, "period flag");
    endtask : t_pwm
    task automatic t_release;
        set_match(1, 32'h6, 1'b0);
        tick(12);
        measure(20);
        check(hc[0] == 10, "unreleased value");
        set_match(1, 32'h6, 1'b1);
        tick(12);
        measure(20);
        check(hc[0] == 14 && hc[3] == 8, "released value");
    endtask : t_release
    task automatic t_ext;
        logic [1:0] code [4] = '{EXT_HIGH, EXT_LOW, EXT_TOGGLE, EXT_NONE};
        logic [31:0] d;
        logic lv;
        int tr;
        do_reset;
        match_action <= 21'h000020;
        set_match(1, 32'h3, 1'b1);
        count_enable <= 1'b1;
        tick(10);
        delta(10, d);
        check(d === ZERO_32 && count_value === 32'h3, "stop");
        match_action <= 21'h000002;
        set_match(0, 32'h4, 1'b1);
        {count_reset, count_enable} <= 2'h2;
        tick(2);
        {count_reset, count_enable} <= 2'h1;
        foreach (code[i])
        begin
            ext_action <= {12'h000, code[i]};
            tick(12);
            @(negedge clock);
            lv = ext_match[0];
            tr = 0;
            repeat (10)
            begin
                @(negedge clock);
                if (ext_match[0] !== lv)
                    tr++;
                lv = ext_match[0];
            end
            check(tr == (code[i] == EXT_TOGGLE ? 2 : 0), "edges");
            if (code[i] == EXT_HIGH || code[i] == EXT_LOW)
                check(lv === code[i][1], "ext level");
            @(posedge clock);
        end
    endtask : t_ext
    task automatic t_capture;
        logic [31:0] cv;
        logic [31:0] want;
        logic [1:0] em [3] = '{MODE_RISE, MODE_FALL, MODE_BOTH};
        do_reset;
        cap_ctrl <= 6'h05;
        count_enable <= 1'b1;
        tick(20);
        cap_pin <= 2'h1;
        tick(8);
        @(negedge clock);
        cv = cap_value[31:0];
        check(cv > 32'h10 && cv < count_value, "capture");
        check(flag_pending[7] === 1'b1, "capture flag");
        @(posedge clock);
        flag_clear <= 9'h080;
        cap_pin <= 2'h0;
        tick(1);
        flag_clear <= 9'h000;
        tick(8);
        @(negedge clock);
        check(flag_pending[7] === 1'b0 && cap_value[31:0] === cv, "clr");
        @(posedge clock);
        // Rise on pin 0, fall on pin 1, both on pin 0, capture flag masked
        cap_ctrl <= 6'h01;
        foreach (em[i])
        begin
            {count_reset, count_mode, count_cap_sel} <= {1'b1, em[i], i[0]};
            tick(2);
            count_reset <= 1'b0;
            want = (em[i] == MODE_BOTH) ? 32'h0A : 32'h05;
            repeat (5)
            begin
                cap_pin <= i[0] ? 2'h2 : 2'h1;
                tick(4);
                cap_pin <= 2'h0;
                tick(4);
            end
            @(negedge clock);
            check(count_value === want, "edge count");
            @(posedge clock);
        end
        check(flag_pending[7] === 1'b0, "masked capture flag");
    endtask : t_capture
    task automatic close_out;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out
    initial
    begin
        num_errors = 0;
        cmp_count = 0;
        {rst_b, count_enable, count_reset, pwm_enable, match_wr} = 5'h00;
        {sync_start, count_cap_sel, count_mode} = 4'h8;
        {prescale_max, match_wr_data, match_wr_idx} = 67'h0;
        {match_release, match_action, ext_action} = 42'h0;
        {double_edge_sel, pwm_out_enable, cap_ctrl, cap_pin} = 20'h0;
        flag_clear = 9'h000;
        t_timer;
        t_pwm;
        t_release;
        t_ext;
        t_capture;
        close_out;
    end
endmodule : tb_top
`default_nettype wire
